// ===== hw/crf_core.sv
// Register file, status flags, ALU, data mapping, prefetch and return push.
`include "crf_consts.svh"
`default_nettype none

// Overview of operation
// - Thirty-two 8-bit registers, each read or written in one cycle.
// - Two operands read, computed and written back within one cycle.
// - ALU does arithmetic, logic, bit and single-register operations.
// - Supports 8/8, 8+8/8, 8+8/16 and 16/16 port schemes.
// - Registers 26 to 31 form three 16-bit pointers.
// - Each register also sits at data address 0 to 31.
// - I/O space of 64 reachable at data 0x20 to 0x5F.
// - Next instruction is fetched while the current one executes.
// - Instructions are one or two 16-bit words.
// - Return program counter pushed on calls and interrupt entry.
// - Lower vector number wins among pending interrupts.
// - Global enable bit 7 low blocks every interrupt.
// - Enable cleared on entry, set on return; software set and clear.
// - Bit copy flag loaded from and stored into register bits.
// - Half carry reports carry out of low nibble.
// - Sign flag equals negative xor overflow, except after a direct flag register write.
// - Overflow flag reports two's complement overflow, except LSR, which loads it with the shifted-out bit.
// - Negative flag equals result most significant bit.
// - Zero flag set on zero result, else cleared.
// - Carry flag reports carry from the operation.
// - Flags updated after every ALU operation except MOV, BLD, CALL and NONE.
// - Flags neither saved nor restored on interrupt entry or return.
module crf_core
    import crf_pkg::*;
(
    input  wire logic        ref_clk,      // CPU clock, 250 MHz.
    input  wire logic        reset_n,      // Asynchronous reset, active low.
    input  wire logic        clk_en,       // Freezes all state but the reset release flops while low.
    input  wire crf_op_t     alu_op,       // Operation this cycle.
    input  wire logic [4:0]  dst_sel,      // Destination register.
    input  wire logic [4:0]  src_sel,      // Source register.
    input  wire logic        use_imm,      // Second operand is immediate.
    input  wire logic [7:0]  imm_val,      // Immediate constant.
    input  wire logic [2:0]  bit_sel,      // Bit for copy operations.
    input  wire logic        data_req,     // Data space access request.
    input  wire logic        data_we,      // Data access is a write.
    input  wire logic [7:0]  data_addr,    // Data space address.
    input  wire logic [7:0]  data_wdata,   // Data write value.
    input  wire logic [7:0]  io_rdata,     // Read value from I/O space.
    input  wire logic [15:0] prog_word,    // Word fetched this cycle.
    input  wire logic [15:0] call_target,  // Target of a call.
    input  wire logic [7:0]  irq_pending,  // Requests, bit 0 lowest vector.
    input  wire logic [15:0] stack_ptr,    // Current stack top address.
    output logic [7:0]       data_rdata,   // Data read value.
    output logic             io_req,       // I/O access strobe.
    output logic             io_we,        // I/O access is a write.
    output logic [5:0]       io_addr,      // I/O address.
    output logic [7:0]       io_wdata,     // I/O write value.
    output logic [15:0]      prog_addr,    // Program fetch address.
    output logic [15:0]      instr_q,      // Prefetched instruction.
    output logic             instr_long,   // Prefetched word opens 32-bit form.
    output logic             push_we,      // Stack write strobe.
    output logic [15:0]      push_addr,    // Stack write address.
    output logic [7:0]       push_data,    // Stack write byte.
    output logic             irq_ack,      // Interrupt taken pulse.
    output logic [2:0]       irq_vector,   // Vector of taken interrupt.
    output logic [7:0]       flags_out,    // Status flag register.
    output logic [15:0]      ptr_a,        // Pointer pair 26/27.
    output logic [15:0]      ptr_b,        // Pointer pair 28/29.
    output logic [15:0]      ptr_c         // Pointer pair 30/31.
);

    // Two-flop reset release; the rest of the design uses rst_n.
    logic rs1_q;
    logic rst_n;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rs1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rst_n <= rs1_q;
        end
    end

    // Flag helper: sign is derived from N and V; only a direct flag register write stores it independently.
    function automatic logic [7:0] fix_sign(input logic [7:0] f);
        logic [7:0] r;
        r = f;
        r[`CRF_BIT_SIGN] = f[`CRF_BIT_NEG] ^ f[`CRF_BIT_OVF];
        return r;
    endfunction

    // Lowest set request index; lower vector has priority.
    function automatic logic [2:0] low_idx(input logic [7:0] v);
        logic [2:0] r;
        r = 3'd0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    logic [7:0]  gpr_q [`CRF_NUM_GPR];
    logic [7:0]  gpr_d [`CRF_NUM_GPR];
    logic [7:0]  flags_q, flags_d;
    logic [15:0] pc_q, pc_d;
    logic [15:0] instr_d;
    logic [15:0] ret_q, ret_d;
    crf_state_t  st_q, st_d;
    logic        push_we_d;
    logic [15:0] push_addr_d;
    logic [7:0]  push_data_d, rdata_d;
    logic        ack_d;
    logic [2:0]  vec_d;
    logic [2:0]  vec_q;

    logic [7:0]  opa, opb, res8;
    logic [8:0]  sum9;
    logic [15:0] w16, r16;
    logic        take_irq;

    // Operand fetch and pointer views are combinational register reads.
    assign opa   = gpr_q[dst_sel];
    assign opb   = use_imm ? imm_val : gpr_q[src_sel];
    assign w16   = {gpr_q[{dst_sel[4:1], 1'b1}], gpr_q[{dst_sel[4:1], 1'b0}]};
    assign ptr_a = {gpr_q[27], gpr_q[26]};
    assign ptr_b = {gpr_q[29], gpr_q[28]};
    assign ptr_c = {gpr_q[31], gpr_q[30]};
    assign take_irq = flags_q[`CRF_BIT_IRQ_EN] && (irq_pending != 8'h00)
                      && st_q == CRF_ST_RUN && alu_op != CRF_OP_RETURN_FROM_IRQ
                      && alu_op != CRF_OP_CLI;

    // I/O window strobes are combinational handshake outputs.
    always_comb begin
        io_req   = 1'b0;
        io_we    = data_we;
        io_addr  = 6'(data_addr - `CRF_IO_BASE);
        io_wdata = data_wdata;
        if (data_req && data_addr >= `CRF_IO_BASE
            && data_addr <= `CRF_IO_LAST) begin
            io_req = 1'b1;
        end
    end

    // ALU, register write-back and flag update; one op per cycle.
    always_comb begin
        for (int i = 0; i < `CRF_NUM_GPR; i++) begin
            gpr_d[i] = gpr_q[i];
        end
        flags_d = flags_q;
        res8 = 8'h00;
        sum9 = 9'h000;
        r16  = 16'h0000;
        case (alu_op)
            CRF_OP_ADD, CRF_OP_ADC: begin
                sum9 = {1'b0, opa} + {1'b0, opb}
                     + {8'h00, alu_op == CRF_OP_ADC && flags_q[0]};
                res8 = sum9[7:0];
                flags_d[`CRF_BIT_HALF] = (opa[3] & opb[3]) | (opb[3] & ~res8[3])
                                       | (~res8[3] & opa[3]);
                flags_d[`CRF_BIT_OVF] = (opa[7] == opb[7])
                                      && (res8[7] != opa[7]);
                flags_d[`CRF_BIT_CARRY] = sum9[8];
            end
            CRF_OP_SUB, CRF_OP_SBC: begin
                sum9 = {1'b0, opa} - {1'b0, opb}
                     - {8'h00, alu_op == CRF_OP_SBC && flags_q[0]};
                res8 = sum9[7:0];
                flags_d[`CRF_BIT_HALF] = (~opa[3] & opb[3]) | (opb[3] & res8[3])
                                       | (res8[3] & ~opa[3]);
                flags_d[`CRF_BIT_OVF] = (opa[7] != opb[7])
                                      && (res8[7] != opa[7]);
                flags_d[`CRF_BIT_CARRY] = sum9[8];
            end
            CRF_OP_AND, CRF_OP_OR, CRF_OP_XOR: begin
                res8 = alu_op == CRF_OP_AND ? (opa & opb) :
                       alu_op == CRF_OP_OR  ? (opa | opb) : (opa ^ opb);
                flags_d[`CRF_BIT_OVF] = 1'b0;
            end
            CRF_OP_INC, CRF_OP_DEC: begin
                res8 = alu_op == CRF_OP_INC ? 8'(opa + 8'h01)
                                            : 8'(opa - 8'h01);
                flags_d[`CRF_BIT_OVF] = alu_op == CRF_OP_INC
                                      ? (opa == 8'h7F) : (opa == 8'h80);
            end
            CRF_OP_COM: begin
                res8 = ~opa;
                flags_d[`CRF_BIT_OVF]   = 1'b0;
                flags_d[`CRF_BIT_CARRY] = 1'b1;
            end
            CRF_OP_NEG: begin
                res8 = 8'(8'h00 - opa);
                flags_d[`CRF_BIT_HALF]  = res8[3] | opa[3];
                flags_d[`CRF_BIT_OVF]   = (res8 == 8'h80);
                flags_d[`CRF_BIT_CARRY] = (res8 != 8'h00);
            end
            CRF_OP_LSR: begin
                res8 = {1'b0, opa[7:1]};
                flags_d[`CRF_BIT_CARRY] = opa[0];
                flags_d[`CRF_BIT_OVF]   = opa[0];
            end
            default: begin
                res8 = opa;
            end
        endcase
        // Eight-bit results write back and set N and Z.
        if (alu_op inside {CRF_OP_ADD, CRF_OP_ADC, CRF_OP_SUB, CRF_OP_SBC,
                           CRF_OP_AND, CRF_OP_OR, CRF_OP_XOR, CRF_OP_INC,
                           CRF_OP_DEC, CRF_OP_COM, CRF_OP_NEG, CRF_OP_LSR})
        begin
            gpr_d[dst_sel] = res8;
            flags_d[`CRF_BIT_NEG]  = res8[7];
            flags_d[`CRF_BIT_ZERO] = (res8 == 8'h00);
            flags_d = fix_sign(flags_d);
        end
        if (alu_op == CRF_OP_MOV) begin
            gpr_d[dst_sel] = opb;
        end
        // Two 8-bit operands to a 16-bit result in registers 1:0.
        if (alu_op == CRF_OP_MUL) begin
            r16 = opa * opb;
            gpr_d[0] = r16[7:0];
            gpr_d[1] = r16[15:8];
            flags_d[`CRF_BIT_CARRY] = r16[15];
            flags_d[`CRF_BIT_ZERO]  = (r16 == 16'h0000);
        end
        // One 16-bit operand to a 16-bit result on a register pair.
        if (alu_op == CRF_OP_ADIW || alu_op == CRF_OP_SBIW) begin
            r16 = alu_op == CRF_OP_ADIW ? 16'(w16 + {10'h000, imm_val[5:0]})
                                        : 16'(w16 - {10'h000, imm_val[5:0]});
            gpr_d[{dst_sel[4:1], 1'b0}] = r16[7:0];
            gpr_d[{dst_sel[4:1], 1'b1}] = r16[15:8];
            flags_d[`CRF_BIT_NEG]   = r16[15];
            flags_d[`CRF_BIT_ZERO]  = (r16 == 16'h0000);
            flags_d[`CRF_BIT_OVF]   = alu_op == CRF_OP_ADIW
                                    ? (~w16[15] & r16[15]) : (w16[15] & ~r16[15]);
            flags_d[`CRF_BIT_CARRY] = alu_op == CRF_OP_ADIW
                                    ? (w16[15] & ~r16[15]) : (~w16[15] & r16[15]);
            flags_d = fix_sign(flags_d);
        end
        if (alu_op == CRF_OP_BST) begin
            flags_d[`CRF_BIT_COPY] = opa[bit_sel];
        end
        if (alu_op == CRF_OP_BLD) begin
            gpr_d[dst_sel][bit_sel] = flags_q[`CRF_BIT_COPY];
        end
        if (alu_op == CRF_OP_SEI || alu_op == CRF_OP_RETURN_FROM_IRQ) begin
            flags_d[`CRF_BIT_IRQ_EN] = 1'b1;
        end
        if (alu_op == CRF_OP_CLI) begin
            flags_d[`CRF_BIT_IRQ_EN] = 1'b0;
        end
        // Data-space writes reach the registers and the flag I/O slot.
        if (data_req && data_we && data_addr < 8'(`CRF_NUM_GPR)) begin
            gpr_d[data_addr[4:0]] = data_wdata;
        end
        if (io_req && data_we && io_addr == `CRF_FLAGS_IO_ADDR) begin
            flags_d = data_wdata;
        end
        // Entry clears only the enable; other flags untouched.
        if (take_irq) begin
            flags_d[`CRF_BIT_IRQ_EN] = 1'b0;
        end
    end

    // Fetch, return push sequencing and data read path.
    always_comb begin
        pc_d        = pc_q + 16'h0001;
        instr_d     = prog_word;
        ret_d       = ret_q;
        st_d        = st_q;
        push_we_d   = 1'b0;
        push_addr_d = stack_ptr;
        push_data_d = 8'h00;
        ack_d       = 1'b0;
        vec_d       = vec_q;
        rdata_d     = io_rdata;
        if (data_addr < 8'(`CRF_NUM_GPR)) begin
            rdata_d = gpr_q[data_addr[4:0]];
        end else if (io_addr == `CRF_FLAGS_IO_ADDR) begin
            rdata_d = flags_q;
        end
        case (st_q)
            CRF_ST_RUN: begin
                if (take_irq) begin
                    ret_d = pc_q;
                    vec_d = low_idx(irq_pending);
                    ack_d = 1'b1;
                    pc_d  = {12'h000, vec_d, 1'b0} + 16'h0002;
                    st_d  = CRF_ST_PUSH;
                end else if (alu_op == CRF_OP_CALL) begin
                    ret_d = pc_q;
                    pc_d  = call_target;
                    st_d  = CRF_ST_PUSH;
                end
            end
            CRF_ST_PUSH: begin
                push_we_d   = 1'b1;
                push_data_d = ret_q[7:0];
                st_d        = CRF_ST_HIGH;
            end
            CRF_ST_HIGH: begin
                push_we_d   = 1'b1;
                push_addr_d = 16'(stack_ptr - 16'h0001);
                push_data_d = ret_q[15:8];
                st_d        = CRF_ST_RUN;
            end
            default: begin
                st_d = CRF_ST_RUN;
            end
        endcase
    end

    // All state registers except the reset release pair; clk_en low holds everything here.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `CRF_NUM_GPR; i++) begin
                gpr_q[i] <= 8'h00;
            end
            flags_q    <= `CRF_FLAGS_RESET;
            pc_q       <= 16'h0000;
            instr_q    <= 16'h0000;
            ret_q      <= 16'h0000;
            st_q       <= CRF_ST_RUN;
            push_we    <= 1'b0;
            push_addr  <= 16'h0000;
            push_data  <= 8'h00;
            irq_ack    <= 1'b0;
            vec_q      <= 3'd0;
            data_rdata <= 8'h00;
        end else if (clk_en) begin
            gpr_q      <= gpr_d;
            flags_q    <= flags_d;
            pc_q       <= pc_d;
            instr_q    <= instr_d;
            ret_q      <= ret_d;
            st_q       <= st_d;
            push_we    <= push_we_d;
            push_addr  <= push_addr_d;
            push_data  <= push_data_d;
            irq_ack    <= ack_d;
            vec_q      <= vec_d;
            data_rdata <= rdata_d;
        end
    end

    // Outputs taken from state; instr_long is decoded from instr_q.
    assign prog_addr  = pc_q;
    assign flags_out  = flags_q;
    assign irq_vector = vec_q;
    assign instr_long = (instr_q[15:10] == 6'b100101) && instr_q[3:2] == 2'b11;

endmodule
`default_nettype wire

// ===== pkg/crf_consts.svh
// Constants for the core register file, status flags and ALU block.
`ifndef CRF_CONSTS_SVH
`define CRF_CONSTS_SVH
`define CRF_NUM_GPR        32
`define CRF_PTR_A_LO       8'h1A
`define CRF_PTR_B_LO       8'h1C
`define CRF_PTR_C_LO       8'h1E
`define CRF_IO_BASE        8'h20
`define CRF_IO_LAST        8'h5F
`define CRF_FLAGS_IO_ADDR  6'h3F
`define CRF_BIT_IRQ_EN     7
`define CRF_BIT_COPY       6
`define CRF_BIT_HALF       5
`define CRF_BIT_SIGN       4
`define CRF_BIT_OVF        3
`define CRF_BIT_NEG        2
`define CRF_BIT_ZERO       1
`define CRF_BIT_CARRY      0
`define CRF_FLAGS_RESET    8'h00
`endif

// ===== pkg/crf_pkg.sv
// Types shared by the core register file block and its bench.
`default_nettype none
package crf_pkg;
    // ALU operation selector.
    typedef enum logic [4:0] {
        CRF_OP_NONE  = 5'h00,
        CRF_OP_ADD   = 5'h01,
        CRF_OP_ADC   = 5'h02,
        CRF_OP_SUB   = 5'h03,
        CRF_OP_SBC   = 5'h04,
        CRF_OP_AND   = 5'h05,
        CRF_OP_OR    = 5'h06,
        CRF_OP_XOR   = 5'h07,
        CRF_OP_MOV   = 5'h08,
        CRF_OP_INC   = 5'h09,
        CRF_OP_DEC   = 5'h0A,
        CRF_OP_COM   = 5'h0B,
        CRF_OP_NEG   = 5'h0C,
        CRF_OP_LSR   = 5'h0D,
        CRF_OP_MUL   = 5'h0E,
        CRF_OP_ADIW  = 5'h0F,
        CRF_OP_SBIW  = 5'h10,
        CRF_OP_BST   = 5'h11,
        CRF_OP_BLD   = 5'h12,
        CRF_OP_SEI   = 5'h13,
        CRF_OP_CLI   = 5'h14,
        CRF_OP_RETURN_FROM_IRQ  = 5'h15,
        CRF_OP_CALL  = 5'h16
    } crf_op_t;
    // Return push sequencer states for calls and interrupt entry, Gray coded from RUN through PUSH to HIGH.
    typedef enum logic [1:0] {
        CRF_ST_RUN  = 2'b00,
        CRF_ST_PUSH = 2'b01,
        CRF_ST_HIGH = 2'b11
    } crf_state_t;
endpackage
`default_nettype wire

// ===== tb/crf_checker.sv
// Port-level assertions for the core register file, flags and ALU block.
`default_nettype none
module crf_checker
    import crf_pkg::*;
(
    input wire logic        ref_clk,     // CPU clock.
    input wire logic        reset_n,     // Reset, active low.
    input wire logic        clk_en,      // Advance enable.
    input wire crf_op_t     alu_op,      // Operation this cycle.
    input wire logic        data_req,    // Data access request.
    input wire logic        data_we,     // Data access is a write.
    input wire logic [7:0]  data_addr,   // Data space address.
    input wire logic [7:0]  data_wdata,  // Data write value.
    input wire logic [7:0]  irq_pending, // Interrupt requests.
    input wire logic [15:0] stack_ptr,   // Stack top address.
    input wire logic        io_req,      // I/O strobe.
    input wire logic [5:0]  io_addr,     // I/O address.
    input wire logic        push_we,     // Stack write strobe.
    input wire logic [15:0] push_addr,   // Stack write address.
    input wire logic        irq_ack,     // Interrupt taken pulse.
    input wire logic [2:0]  irq_vector,  // Taken vector.
    input wire logic [7:0]  flags_out,   // Status flags.
    input wire logic [15:0] prog_addr,   // Fetch address.
    input wire logic [15:0] ptr_a        // Pointer pair 26/27.
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Requests as seen at the deciding edge; the taken vector is judged here.
    logic [7:0] pend_q;
    always_ff @(posedge ref_clk) begin
        pend_q <= irq_pending;
    end

    // Return address goes out low byte first, then high byte one below.
    sequence push_pair_s;
        push_we && !irq_ack && push_addr == stack_ptr
        ##1 push_we && push_addr == stack_ptr - 16'h0001
        ##1 !push_we;
    endsequence

    chk_io_window:
        assert property (data_req && data_addr >= 8'h20 && data_addr <= 8'h5F
            |-> io_req && io_addr == 6'(data_addr - 8'h20))
        else $error("I/O window mapping wrong.");
    chk_reg_no_io:
        assert property (data_req && data_addr <= 8'h1F |-> !io_req)
        else $error("Register address leaked to I/O.");
    chk_ptr_write:
        assert property (clk_en && data_req && data_we && data_addr == 8'h1A
            |=> ptr_a[7:0] == $past(data_wdata))
        else $error("Pointer low byte not at 0x1A.");
    chk_sign_add:
        assert property (clk_en && alu_op == CRF_OP_ADD && !data_req
            |=> flags_out[4] == (flags_out[2] ^ flags_out[3]))
        else $error("Sign flag not negative xor overflow.");
    chk_irq_gate:
        assert property (clk_en && !flags_out[7] |=> !irq_ack)
        else $error("Interrupt taken while globally disabled.");
    chk_irq_entry:
        assert property (irq_ack |-> !flags_out[7]
            && prog_addr == {12'h000, irq_vector, 1'b0} + 16'h0002)
        else $error("Interrupt entry state wrong.");
    chk_irq_prio:
        assert property (irq_ack |-> pend_q[irq_vector]
            && (pend_q & ((8'h01 << irq_vector) - 8'h01)) == 8'h00)
        else $error("Lower vector did not win.");
    chk_push_pair:
        assert property (irq_ack |=> push_pair_s)
        else $error("Return address push wrong.");
    chk_cli_block:
        assert property (clk_en && alu_op == CRF_OP_CLI && !data_req
            |=> !irq_ack && !flags_out[7])
        else $error("Interrupt taken beside clear.");
    chk_flags_reset:
        assert property ($rose(reset_n) |-> flags_out == 8'h00)
        else $error("Flags not zero out of reset.");
endmodule

bind crf_core crf_checker crf_checker_inst (
    .ref_clk, .reset_n, .clk_en, .alu_op, .data_req, .data_we, .data_addr,
    .data_wdata, .irq_pending, .stack_ptr, .io_req, .io_addr, .push_we,
    .push_addr, .irq_ack, .irq_vector, .flags_out, .prog_addr, .ptr_a
);
`default_nettype wire

// ===== tb/crf_core_bench.sv
// Self-checking bench for the core register file, flags and ALU block.
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
    fail_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); end end
module crf_core_bench
    import crf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk     = 1'b0;
    logic        reset_n     = 1'b0;
    logic        clk_en      = 1'b1;
    crf_op_t     alu_op      = CRF_OP_NONE;
    logic [4:0]  dst_sel     = 5'h00;
    logic [4:0]  src_sel     = 5'h00;
    logic        use_imm     = 1'b0;
    logic [7:0]  imm_val     = 8'h00;
    logic [2:0]  bit_sel     = 3'h0;
    logic        data_req    = 1'b0;
    logic        data_we     = 1'b0;
    logic [7:0]  data_addr   = 8'h00;
    logic [7:0]  data_wdata  = 8'h00;
    logic [7:0]  io_rdata    = 8'h00;
    logic [15:0] prog_word   = 16'h0000;
    logic [15:0] call_target = 16'h0000;
    logic [7:0]  irq_pending = 8'h00;
    logic [15:0] stack_ptr   = 16'h0400;
    logic [7:0]  data_rdata, flags_out, io_wdata, push_data;
    logic        io_we, instr_long;
    logic [5:0]  io_addr;
    logic [15:0] prog_addr, instr_q, push_addr, ptr_a, ptr_b, ptr_c;
    logic [2:0]  irq_vector;
    logic        io_req, push_we, irq_ack;
    int          fail_count  = 0;
    int          num_checks  = 0;

    crf_core crf_core_inst (
        .ref_clk, .reset_n, .clk_en, .alu_op, .dst_sel, .src_sel,
        .use_imm, .imm_val, .bit_sel, .data_req, .data_we, .data_addr,
        .data_wdata, .io_rdata, .prog_word, .call_target, .irq_pending,
        .stack_ptr, .data_rdata, .io_req, .io_we, .io_addr, .io_wdata,
        .prog_addr, .instr_q, .instr_long, .push_we, .push_addr,
        .push_data, .irq_ack, .irq_vector, .flags_out, .ptr_a, .ptr_b,
        .ptr_c
    );

    // Free-running CPU clock, 4 ns period.
    always #2 ref_clk = ~ref_clk;

    // One full cycle of stimulus; the data request, address, write data, operation and operand inputs except bit_sel are driven each time so that
    // a leftover request from the previous cycle can never repeat.
    task automatic cyc(input logic rq, we, input logic [7:0] a, wd,
                       input crf_op_t o, input logic [4:0] d,
                       input logic im, input logic [7:0] k);
        data_req = rq;
        data_we = we;
        data_addr = a;
        data_wdata = wd;
        alu_op = o;
        dst_sel = d;
        src_sel = d + 5'd1;
        use_imm = im;
        imm_val = k;
        @(negedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, d);
        cyc(1'b1, 1'b1, a, d, CRF_OP_NONE, 5'd0, 1'b0, 8'h00);
    endtask

    // Read data is registered, so it is taken one cycle after the request.
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        cyc(1'b1, 1'b0, a, 8'h00, CRF_OP_NONE, 5'd0, 1'b0, 8'h00);
        v = data_rdata;
    endtask

    task automatic op(input crf_op_t o, input logic [4:0] d,
                      input logic im, input logic [7:0] k);
        cyc(1'b0, 1'b0, 8'h00, 8'h00, o, d, im, k);
    endtask

    task automatic test_regs();
        logic [7:0] v;
        for (int i = 0; i < 32; i++) begin
            wr(8'(i), 8'(i * 7 + 3));
        end
        for (int i = 0; i < 32; i++) begin
            rd(8'(i), v);
            `CHK(v, 8'(i * 7 + 3));
        end
        `CHK(ptr_a, {8'(27 * 7 + 3), 8'(26 * 7 + 3)});
        `CHK(ptr_b, {8'(29 * 7 + 3), 8'(28 * 7 + 3)});
        `CHK(ptr_c, {8'(31 * 7 + 3), 8'(30 * 7 + 3)});
        $display("test regs done");
    endtask

    task automatic test_alu();
        logic [7:0] v;
        wr(8'h01, 8'h7F);
        wr(8'h02, 8'h01);
        op(CRF_OP_ADD, 5'd1, 1'b0, 8'h00);
        `CHK(flags_out, 8'h2C);
        rd(8'h01, v);
        `CHK(v, 8'h80);
        op(CRF_OP_SUB, 5'd1, 1'b1, 8'h80);
        `CHK(flags_out, 8'h02);
        rd(8'h01, v);
        `CHK(v, 8'h00);
        wr(8'h03, 8'hFF);
        wr(8'h04, 8'h01);
        op(CRF_OP_ADD, 5'd3, 1'b0, 8'h00);
        `CHK(flags_out, 8'h23);
        bit_sel = 3'd7;
        wr(8'h05, 8'h80);
        op(CRF_OP_BST, 5'd5, 1'b0, 8'h00);
        `CHK(flags_out, 8'h63);
        bit_sel = 3'd1;
        op(CRF_OP_BLD, 5'd6, 1'b0, 8'h00);
        rd(8'h06, v);
        `CHK(v, 8'h2F);
        wr(8'h1A, 8'hFF);
        wr(8'h1B, 8'h00);
        op(CRF_OP_ADIW, 5'd26, 1'b1, 8'h01);
        `CHK(ptr_a, 16'h0100);
        $display("test alu done");
    endtask

    task automatic test_io();
        logic [7:0] v;
        io_rdata = 8'h3C;
        rd(8'h25, v);
        `CHK(v, 8'h3C);
        wr(8'h5F, 8'h15);
        `CHK(flags_out, 8'h15);
        `CHK(io_we, 1'b1);
        `CHK(io_wdata, 8'h15);
        rd(8'h5F, v);
        `CHK(v, 8'h15);
        $display("test io done");
    endtask

    // Flags other than the enable must come through entry untouched.
    task automatic test_irq();
        wr(8'h5F, 8'h0D);
        irq_pending = 8'h01;
        op(CRF_OP_NONE, 5'd0, 1'b0, 8'h00);
        irq_pending = 8'h00;
        op(CRF_OP_SEI, 5'd0, 1'b0, 8'h00);
        `CHK(irq_ack, 1'b0);
        `CHK(flags_out, 8'h8D);
        irq_pending = 8'h0C;
        op(CRF_OP_NONE, 5'd0, 1'b0, 8'h00);
        irq_pending = 8'h00;
        `CHK(irq_ack, 1'b1);
        `CHK(irq_vector, 3'd2);
        `CHK(prog_addr, 16'h0006);
        `CHK(flags_out, 8'h0D);
        op(CRF_OP_NONE, 5'd0, 1'b0, 8'h00);
        `CHK(push_we, 1'b1);
        `CHK(push_addr, 16'h0400);
        op(CRF_OP_NONE, 5'd0, 1'b0, 8'h00);
        `CHK(push_addr, 16'h03FF);
        op(CRF_OP_RETURN_FROM_IRQ, 5'd0, 1'b0, 8'h00);
        `CHK(flags_out, 8'h8D);
        irq_pending = 8'h01;
        op(CRF_OP_CLI, 5'd0, 1'b0, 8'h00);
        `CHK(irq_ack, 1'b0);
        irq_pending = 8'h00;
        `CHK(flags_out, 8'h0D);
        $display("test irq done");
    endtask

    // Call pushes two bytes; a frozen clock enable must hold the flags.
    task automatic test_call();
        int n;
        logic [15:0] ra;
        n = 0;
        call_target = 16'h0123;
        op(CRF_OP_CALL, 5'd0, 1'b0, 8'h00);
        for (int i = 0; i < 4; i++) begin
            n += int'(push_we === 1'b1);
            op(CRF_OP_NONE, 5'd0, 1'b0, 8'h00);
        end
        `CHK(n, 2);
        prog_word = 16'h940E;
        op(CRF_OP_NONE, 5'd0, 1'b0, 8'h00);
        `CHK(instr_q, 16'h940E);
        `CHK(instr_long, 1'b1);
        clk_en = 1'b0;
        op(CRF_OP_ADD, 5'd3, 1'b0, 8'h00);
        `CHK(flags_out, 8'h0D);
        clk_en = 1'b1;
        // The return address pushed is the fetch address of the call cycle.
        ra = prog_addr;
        op(CRF_OP_CALL, 5'd0, 1'b0, 8'h00);
        op(CRF_OP_NONE, 5'd0, 1'b0, 8'h00);
        `CHK(push_data, ra[7:0]);
        op(CRF_OP_NONE, 5'd0, 1'b0, 8'h00);
        `CHK(push_data, ra[15:8]);
        $display("test call done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence: reset for eight cycles, then the scenarios in turn.
    initial begin
        repeat (8) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHK(flags_out, 8'h00);
        test_regs();
        test_alu();
        test_io();
        test_irq();
        test_call();
        complete_run();
    end

    // Watchdog: the whole run needs about 110 cycles, so 2000 means a hang.
    initial begin
        repeat (2000) @(posedge ref_clk);
        fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire
